//--- logic/sesc_select_ctrl.sv
// Functional notes
// - Low select level means selected; serial traffic accepted only while low.
// - Select high deselects and enters standby unless programming runs or deep power-down is entered or held.
// - A started programming cycle always runs to completion.
// - Select raised during programming: standby right after the cycle ends.
// - Serial output is high impedance whenever deselected.
// - Select rising after a complete valid write sequence starts the write cycle.
// - Serial output updates after each falling serial clock edge.
// - Byte, page write and page erase finish within 6 ms.
// - Whole-array erase finishes within 10 ms.
// - Sector erase finishes within 10 ms.
// - With nothing pending, standby is reached within 100 us of select rise.
// - Deep-sleep command ends in deep power-down within 100 us.
// - Serial input captured on rising clock edges, most significant bit first.
// - Write latch set only at select rise after exactly eight command bits.
// - Code B9 enters deep power-down; AB releases it and returns signature.
`timescale 1ns/1ps
`default_nettype none
module sesc_select_ctrl #(
  parameter logic [sesc_pkg::TMR_W-1:0] WRITE_CYCLES =
    sesc_pkg::TMR_W'(sesc_pkg::WRITE_CYCLES),
  parameter logic [sesc_pkg::TMR_W-1:0] SECTOR_CYCLES =
    sesc_pkg::TMR_W'(sesc_pkg::SECTOR_ERASE_CYCLES),
  parameter logic [sesc_pkg::TMR_W-1:0] ARRAY_CYCLES =
    sesc_pkg::TMR_W'(sesc_pkg::ARRAY_ERASE_CYCLES),
  parameter logic [7:0] SIGNATURE = sesc_pkg::SIGNATURE_DEFAULT
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Array side
  input wire logic [7:0] rd_data_i,
  output logic rd_next_o,
  output sesc_pkg::sesc_prog_t prog_o,
  output sesc_pkg::sesc_status_t status_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] cs_sync_reg;
  logic [2:0] sck_sync_reg;
  logic [1:0] si_sync_reg;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h0;
      si_sync_reg <= 2'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n_i};
      sck_sync_reg <= {sck_sync_reg[1:0], sck_i};
      si_sync_reg <= {si_sync_reg[0], si_i};
    end
  end

  wire cs_hi = cs_sync_reg[1];
  wire cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
  wire si_s = si_sync_reg[1];

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  sesc_pkg::sesc_state_t state_reg, state_next;
  logic [5:0] cnt_reg;
  logic [7:0] in_sr_reg;
  logic [7:0] op_reg;
  logic data_seen_reg;
  logic wel_reg;
  logic [7:0] out_sr_reg;
  logic [sesc_pkg::TMR_W-1:0] tmr_reg;
  logic [sesc_pkg::TMR_W-1:0] lim_m1_reg;
  logic [1:0] kind_reg;

  wire listening = (state_reg == sesc_pkg::ST_SELECT) |
                   (state_reg == sesc_pkg::ST_SLEEP);
  wire shift_en = listening & ~cs_hi & sck_rise;
  wire op_done = cnt_reg == sesc_pkg::BITS_OPCODE;
  wire addr_done = cnt_reg == sesc_pkg::BITS_ADDR_END;
  wire is_read = op_reg == sesc_pkg::OP_READ;
  wire is_wake = op_reg == sesc_pkg::OP_WAKE_SIGNATURE;
  wire out_phase = listening & ~cs_hi & (is_read | is_wake) &
                   (cnt_reg >= sesc_pkg::BITS_ADDR_END);
  wire sleeping = state_reg == sesc_pkg::ST_SLEEP;
  wire in_select = state_reg == sesc_pkg::ST_SELECT;

  wire wr_ok = (op_reg == sesc_pkg::OP_WRITE) & data_seen_reg & addr_done;
  wire pe_ok = (op_reg == sesc_pkg::OP_PAGE_ERASE) & ~data_seen_reg & addr_done;
  wire se_ok = (op_reg == sesc_pkg::OP_SECTOR_ERASE) & ~data_seen_reg & addr_done;
  wire ce_ok = (op_reg == sesc_pkg::OP_ARRAY_ERASE) & op_done;
  wire launch = in_select & cs_rise & wel_reg & (wr_ok | pe_ok | se_ok | ce_ok);
  wire write_latch_set_command_ok = in_select & cs_rise & op_done &
                 (op_reg == sesc_pkg::OP_WRITE_LATCH_SET);
  wire wrdi_ok = in_select & cs_rise & op_done &
                 (op_reg == sesc_pkg::OP_WRITE_LATCH_CLR);
  wire sleep_ok = in_select & cs_rise & op_done &
                  (op_reg == sesc_pkg::OP_DEEP_SLEEP);
  wire wake_ok = sleeping & cs_rise & is_wake &
                 (cnt_reg >= sesc_pkg::BITS_OPCODE);
  wire tmr_done = tmr_reg == lim_m1_reg;

  wire [1:0] kind_next = pe_ok ? sesc_pkg::PK_PAGE_ERASE :
                         se_ok ? sesc_pkg::PK_SECTOR_ERASE :
                         ce_ok ? sesc_pkg::PK_ARRAY_ERASE : sesc_pkg::PK_WRITE;
  // Write and page erase share the short limit; sector and array erase take the long ones
  wire [sesc_pkg::TMR_W-1:0] lim_next =
    se_ok ? SECTOR_CYCLES : ce_ok ? ARRAY_CYCLES : WRITE_CYCLES;

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sesc_pkg::ST_POWERUP: begin
        if (!cs_hi) state_next = sesc_pkg::ST_STANDBY;
      end
      sesc_pkg::ST_STANDBY: begin
        // Only a fresh falling select opens a frame, so no mid-frame entry
        if (!cs_hi && cs_sync_reg[2]) state_next = sesc_pkg::ST_SELECT;
      end
      sesc_pkg::ST_SELECT: begin
        if (launch) state_next = sesc_pkg::ST_PROGRAM;
        else if (sleep_ok) state_next = sesc_pkg::ST_SLEEP;
        else if (cs_hi) state_next = sesc_pkg::ST_STANDBY;
      end
      sesc_pkg::ST_PROGRAM: begin
        if (tmr_done) state_next = sesc_pkg::ST_STANDBY;
      end
      sesc_pkg::ST_SLEEP: begin
        if (wake_ok) state_next = sesc_pkg::ST_STANDBY;
      end
      default: state_next = sesc_pkg::ST_POWERUP;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) state_reg <= sesc_pkg::ST_POWERUP;
    else state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Serial input shifting
  // ----------------------------------------------------------------
  wire wrap = cnt_reg == sesc_pkg::BITS_BYTE_LAST;
  wire [5:0] cnt_next = wrap ? sesc_pkg::BITS_ADDR_END : cnt_reg + 6'h01;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= 6'h00;
      in_sr_reg <= 8'h00;
      op_reg <= 8'h00;
      data_seen_reg <= 1'b0;
    end else if (cs_hi) begin
      cnt_reg <= 6'h00;
      data_seen_reg <= 1'b0;
    end else if (shift_en) begin
      cnt_reg <= cnt_next;
      in_sr_reg <= {in_sr_reg[6:0], si_s};
      if (cnt_reg == sesc_pkg::BITS_OPCODE - 6'h01) op_reg <= {in_sr_reg[6:0], si_s};
      if (wrap) data_seen_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write latch and program timer
  // ----------------------------------------------------------------
  // Set wins over clear; the two come from different commands so never meet
  wire wel_next = write_latch_set_command_ok ? 1'b1 : (wrdi_ok | launch) ? 1'b0 : wel_reg;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) wel_reg <= 1'b0;
    else wel_reg <= wel_next;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tmr_reg <= '0;
      lim_m1_reg <= '0;
      kind_reg <= sesc_pkg::PK_WRITE;
      prog_o <= '0;
    end else begin
      prog_o.start <= launch;
      prog_o.kind <= launch ? kind_next : kind_reg;
      if (launch) begin
        tmr_reg <= '0;
        lim_m1_reg <= lim_next - sesc_pkg::TMR_W'(1);
        kind_reg <= kind_next;
      end else if (state_reg == sesc_pkg::ST_PROGRAM) begin
        tmr_reg <= tmr_reg + sesc_pkg::TMR_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  wire first_bit = cnt_reg[2:0] == sesc_pkg::BYTE_FIRST_BIT;
  wire [7:0] new_byte = is_wake ? SIGNATURE : rd_data_i;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      out_sr_reg <= 8'h00;
      rd_next_o <= 1'b0;
    end else begin
      so_oe_o <= out_phase;
      rd_next_o <= out_phase & sck_fall & first_bit & is_read;
      if (out_phase && sck_fall) begin
        if (first_bit) begin
          so_o <= new_byte[7];
          out_sr_reg <= {new_byte[6:0], 1'b0};
        end else begin
          so_o <= out_sr_reg[7];
          out_sr_reg <= {out_sr_reg[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Registered from the next state so the flags line up with state_reg
  // and leave the block straight from flops
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_o <= '0;
    end else begin
      status_o <= '{busy: state_next == sesc_pkg::ST_PROGRAM,
                    standby: state_next == sesc_pkg::ST_STANDBY,
                    sleep: state_next == sesc_pkg::ST_SLEEP,
                    wel: wel_next};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_select_gates_shift: assert property (
    cs_hi |=> (cnt_reg == 6'h00)) else $error("frame count kept while deselected");
  a_deselect_standby: assert property (
    in_select && cs_hi && !launch && !sleep_ok |=> status_o.standby)
    else $error("no standby after deselect");
  a_program_holds: assert property (
    status_o.busy && !tmr_done |=> status_o.busy) else $error("program cut short");
  a_standby_after_prog: assert property (
    status_o.busy && tmr_done |=> status_o.standby) else $error("no standby after program");
  a_deselect_hiz: assert property (
    cs_hi |=> !so_oe_o) else $error("output driven while deselected");
  a_launch_start: assert property (
    launch |=> prog_o.start ##1 status_o.busy) else $error("write cycle not started");
  a_powerup_quiet: assert property (
    state_reg == sesc_pkg::ST_POWERUP |=> !status_o.busy) else $error("busy before select");
  a_out_on_fall: assert property (
    $changed(so_o) |-> $past(sck_fall)) else $error("output moved without falling clock");
  a_write_limit: assert property (
    status_o.busy && kind_reg[1] == 1'b0 |-> tmr_reg < WRITE_CYCLES)
    else $error("write cycle too long");
  a_array_limit: assert property (
    status_o.busy && kind_reg == sesc_pkg::PK_ARRAY_ERASE |-> tmr_reg < ARRAY_CYCLES)
    else $error("array erase too long");
  a_sector_limit: assert property (
    status_o.busy && kind_reg == sesc_pkg::PK_SECTOR_ERASE |-> tmr_reg < SECTOR_CYCLES)
    else $error("sector erase too long");
  a_standby_entry: assert property (
    in_select && cs_rise && !launch && !sleep_ok |-> ##[1:2] status_o.standby)
    else $error("standby entry late");
  a_sleep_entry: assert property (
    sleep_ok |-> ##[1:2] status_o.sleep) else $error("deep sleep entry late");
  a_latch_set: assert property (
    $rose(status_o.wel) |-> $past(op_done && cs_rise)) else $error("latch set wrongly");
  a_shift_msb_first: assert property (
    shift_en |=> in_sr_reg[0] == $past(si_s)) else $error("serial bit not shifted in");
  a_idle_ignores_pins: assert property (
    !listening |=> $stable(in_sr_reg)) else $error("input shifted while not listening");
  a_wake_standby: assert property (
    wake_ok |=> status_o.standby) else $error("no standby after wake");

  c_write_cycle: cover property (launch && wr_ok ##[1:4] status_o.busy);
  c_sleep_wake: cover property (sleep_ok ##[1:1000] wake_ok);
  c_read_byte: cover property (rd_next_o && is_read);
  c_raise_in_prog: cover property (status_o.busy && cs_rise);
  c_wake_signature: cover property (out_phase && is_wake && sck_fall);
endmodule : sesc_select_ctrl
`default_nettype wire

//--- logic/sesc_pkg.sv
`default_nettype none
package sesc_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int MCLK_HZ = 40_000_000;
  localparam int WRITE_CYCLE_TIME_MS = 6;
  localparam int ARRAY_ERASE_TIME_MS = 10;
  localparam int SECTOR_ERASE_TIME_MS = 10;
  localparam int STANDBY_ENTRY_TIME_US = 100;
  localparam int DEEP_SLEEP_TIME_US = 100;
  // Longest times round down to whole cycles
  localparam int WRITE_CYCLES = WRITE_CYCLE_TIME_MS * (MCLK_HZ / 1000);
  localparam int ARRAY_ERASE_CYCLES = ARRAY_ERASE_TIME_MS * (MCLK_HZ / 1000);
  localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_MS * (MCLK_HZ / 1000);
  localparam int STANDBY_ENTRY_CYCLES = STANDBY_ENTRY_TIME_US * (MCLK_HZ / 1_000_000);
  localparam int DEEP_SLEEP_CYCLES = DEEP_SLEEP_TIME_US * (MCLK_HZ / 1_000_000);
  localparam int TMR_W = 19;

  // ----------------------------------------------------------------
  // Command codes and frame lengths
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h42;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] OP_ARRAY_ERASE = 8'hC7;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_SIGNATURE = 8'hAB;
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ADDR_END = 6'h20;
  localparam logic [5:0] BITS_BYTE_LAST = 6'h27;
  localparam logic [2:0] BYTE_FIRST_BIT = 3'h0;
  // Arbitrary signature value, not tied to any real part
  localparam logic [7:0] SIGNATURE_DEFAULT = 8'h5A;

  // ----------------------------------------------------------------
  // Program kinds and carriers
  // ----------------------------------------------------------------
  localparam logic [1:0] PK_WRITE = 2'h0;
  localparam logic [1:0] PK_PAGE_ERASE = 2'h1;
  localparam logic [1:0] PK_SECTOR_ERASE = 2'h2;
  localparam logic [1:0] PK_ARRAY_ERASE = 2'h3;

  typedef enum logic [4:0] {
    ST_POWERUP = 5'b00001,
    ST_STANDBY = 5'b00010,
    ST_SELECT = 5'b00100,
    ST_PROGRAM = 5'b01000,
    ST_SLEEP = 5'b10000
  } sesc_state_t;

  typedef struct packed {
    logic start;
    logic [1:0] kind;
  } sesc_prog_t;

  typedef struct packed {
    logic busy;
    logic standby;
    logic sleep;
    logic wel;
  } sesc_status_t;
endpackage : sesc_pkg
`default_nettype wire

//--- tb/sesc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sesc_host_model (
  // Clock
  input wire logic mclk_i,
  // Serial pins
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  logic so_last;
  logic so_line;
  // A released line must not look like valid data, so it toggles
  assign so_line = so_oe_i ? so_i : ~so_last;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    so_last = 1'b0;
  end
  always @(posedge mclk_i) so_last <= so_line;

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wait_n

  task automatic open_frame();
    @(posedge mclk_i) cs_n_o <= 1'b0;
    wait_n(4);
  endtask : open_frame

  // Clock idles low between frames; 4 mclk high and 4 low gives 200 ns
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      si_o <= tx[i];
      wait_n(4);
      sck_o <= 1'b1;
      wait_n(4);
      // Late sample: the bit launched on the last fall is still standing
      rx = {rx[6:0], so_line};
      sck_o <= 1'b0;
    end
  endtask : xfer

  task automatic close_frame();
    wait_n(4);
    cs_n_o <= 1'b1;
    wait_n(6);
  endtask : close_frame
endmodule : sesc_host_model
`default_nettype wire

//--- tb/serial_eeprom_select_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_select_control_test;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] rd_data = 8'hA5;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic rd_next;
  sesc_pkg::sesc_prog_t prog;
  sesc_pkg::sesc_status_t status;
  int errors = 0;
  int comparisons = 0;

  always #12.5 mclk = ~mclk;
  // Array side: next byte is the inverse of the last one
  always @(posedge mclk) if (rd_next === 1'b1) rd_data <= ~rd_data;

  sesc_select_ctrl #(
    .WRITE_CYCLES(19'h96),
    .SECTOR_CYCLES(19'h50),
    .ARRAY_CYCLES(19'h64)
  ) u_dut (
    .mclk_i(mclk), .arst_n_i(arst_n), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .rd_data_i(rd_data), .rd_next_o(rd_next),
    .prog_o(prog), .status_o(status)
  );
  sesc_host_model u_host (
    .mclk_i(mclk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so), .so_oe_i(so_oe)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic cmd(input logic [7:0] op, input int nbits);
    logic [7:0] rx;
    u_host.open_frame();
    u_host.xfer(op, nbits, rx);
    u_host.close_frame();
  endtask : cmd

  task automatic addr_frame(input logic [7:0] op, input int nbytes);
    logic [7:0] rx;
    u_host.open_frame();
    u_host.xfer(op, 8, rx);
    for (int i = 0; i < nbytes; i++) u_host.xfer(8'h10 + i, 8, rx);
  endtask : addr_frame

  task automatic wait_prog(input logic [1:0] kind, input int cyc);
    int n;
    n = 0;
    // Sample on the falling edge, away from the edge that moves the flags
    @(negedge mclk);
    while (prog.start !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 400, 1);
    if (n == 400) test_done();
    chk(prog.kind, kind);
    n = 0;
    while (status.busy === 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    chk(n, cyc);
    if (n == 1000) test_done();
    chk(status.standby, 1);
  endtask : wait_prog

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup();
    cmd(8'h06, 8);
    chk(status.wel, 0);
    $display("t_powerup done");
  endtask : t_powerup

  task automatic t_latch();
    cmd(8'h06, 7);
    chk(status.wel, 0);
    cmd(8'h06, 8);
    chk(status.wel, 1);
    chk(status.standby, 1);
    chk(so_oe, 0);
    cmd(8'h04, 8);
    chk(status.wel, 0);
    $display("t_latch done");
  endtask : t_latch

  task automatic t_write();
    cmd(8'h06, 8);
    addr_frame(8'h02, 4);
    fork
      wait_prog(2'h0, 150);
      begin
        u_host.close_frame();
        u_host.wait_n(10);
        cmd(8'h06, 8);
      end
    join
    chk(status.wel, 0);
    $display("t_write done");
  endtask : t_write

  task automatic t_erase();
    logic [7:0] ops [3] = '{8'h42, 8'hD8, 8'hC7};
    int cycs [3] = '{150, 80, 100};
    int nadr [3] = '{3, 3, 0};
    for (int k = 0; k < 3; k++) begin
      cmd(8'h06, 8);
      addr_frame(ops[k], nadr[k]);
      fork
        wait_prog(2'(k + 1), cycs[k]);
        u_host.close_frame();
      join
    end
    $display("t_erase done");
  endtask : t_erase

  task automatic t_read();
    logic [7:0] rx;
    addr_frame(8'h03, 3);
    u_host.xfer(8'h00, 8, rx);
    chk(rx, 8'hA5);
    chk(so_oe, 1);
    u_host.xfer(8'h00, 8, rx);
    chk(rx, 8'h5A);
    u_host.close_frame();
    chk(so_oe, 0);
    $display("t_read done");
  endtask : t_read

  task automatic t_sleep();
    logic [7:0] rx;
    cmd(8'hB9, 8);
    chk(status.sleep, 1);
    cmd(8'h06, 8);
    chk(status.wel, 0);
    addr_frame(8'hAB, 3);
    u_host.xfer(8'h00, 8, rx);
    chk(rx, sesc_pkg::SIGNATURE_DEFAULT);
    u_host.close_frame();
    chk(status.sleep, 0);
    chk(status.standby, 1);
    $display("t_sleep done");
  endtask : t_sleep

  initial begin
    repeat (3) @(posedge mclk);
    chk(status, 4'h0);
    chk(so_oe, 0);
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    u_host.wait_n(4);
    t_powerup();
    t_latch();
    t_write();
    t_erase();
    t_read();
    t_sleep();
    test_done();
  end
endmodule : serial_eeprom_select_control_test
`default_nettype wire
